// ==== common/spi_cmd_defs.svh ====
// Behaviour
// R1 - each select frame opens with a command byte; later bytes are its data
// R2 - top two command bits are function code, low six bits are the payload
// R3 - code 00 writes the next data byte to the addressed control register
// R4 - write is single per frame, or burst while select stays high
// R5 - code 01 returns the addressed control register on the data line
// R6 - host never sends reserved function code 10; the testbench sends 0x84 once and the frame is skipped
// R7 - code 11 is a transmit command; low six bits are transmit fields
// R8 - host writes only register addresses 0x04 to 0x27
// R9 - host sends the transmit command byte first, then the datagram
// R10 - field A enables data sync; host sets C whenever A is set
// R11 - B at 0: amplifier off at select fall, bit-aligned when A set
// R12 - B at 1: latch data at select fall, hold, then off after 65536 periods
// R13 - C at 1 enables the encoder with the configured scheme, else bypass
// R14 - D selects power and modulation setting one or two
// R15 - fields E,F select frequency channel A to D
// R16 - host waits 100 us after the transmit command before data
// R17 - host keeps the serial clock still during transmission; host_spi_model toggles it to shift the datagram in
// R18 - host keeps encoder on in synchronous mode, NRZ for no coding
// R19 - one chip per bit for NRZ, two chips per bit otherwise; the code sends every bit as two chips, NRZ as two equal chips
// R20 - schemes: Manchester, diff Manchester, biphase space/mark, Miller, NRZ, PRBS9
// R21 - scheme from bits 2:0 at 0x05, bit 3 inverts the chip stream
// R22 - count at 0x27 leaves that many leading bits plain before encoding
// R23 - transmit fields A..F sit on command bits 5 down to 0
// R24 - burst write increments the address after each data byte
`ifndef SPI_CMD_DEFS_SVH
`define SPI_CMD_DEFS_SVH

`define FC_WRITE        2'h0
`define FC_READ         2'h1
`define FC_RESERVED     2'h2
`define FC_TRANSMIT     2'h3

`define ADDR_TX_CFG_ONE 6'h05
`define ADDR_PRBS_SEED  6'h08
`define ADDR_ENC_COUNT  6'h27

`define TX_CFG_INV_BIT  3
`define TX_CFG_RST      8'h25
`define PRBS_SEED_RST   8'hAB
`define ENC_COUNT_RST   8'h00

`define HOLD_CYCLES_DEF 65536
`define CHIP_CYCLES     8
`define BIT_CYCLES      (2 * `CHIP_CYCLES)

`endif

// ==== common/spi_cmd_pkg.sv ====
package spi_cmd_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_CMD  = 6'b00_0010,
    ST_WR   = 6'b00_0100,
    ST_RD   = 6'b00_1000,
    ST_TX   = 6'b01_0000,
    ST_SKIP = 6'b10_0000
  } spi_state_t;

  typedef enum logic [2:0] {
    SCH_MANCH   = 3'h0,
    SCH_DIFFMAN = 3'h1,
    SCH_BISPACE = 3'h2,
    SCH_BIMARK  = 3'h3,
    SCH_MILLER  = 3'h4,
    SCH_NRZ     = 3'h5,
    SCH_PRBS    = 3'h6,
    SCH_ZERO    = 3'h7
  } scheme_t;

  typedef struct packed {
    logic       dataSync;
    logic       paHold;
    logic       encEn;
    logic       pwrSel;
    logic [1:0] chan;
  } tx_cmd_t;

endpackage : spi_cmd_pkg

// ==== rtl/sync_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  property p_no_overfill;
    @(posedge clk) disable iff (sys_rst)
      !inReady |=> count_q == (AW+1)'(DEPTH) || $past(pop);
  endproperty
  a_no_overfill : assert property (p_no_overfill)
    else $error("fifo count moved above depth");
endmodule : sync_fifo
`default_nettype wire

// ==== rtl/spi_command_and_data_encoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "spi_cmd_defs.svh"
module spi_command_and_data_encoder import spi_cmd_pkg::*; #(
  parameter int unsigned HOLD_CYCLES = `HOLD_CYCLES_DEF
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       spiEn,
  input  wire logic       spiSck,
  input  wire logic       sdioIn,
  output logic            sdioOut,
  output logic            sdioOe_n,
  output logic            paOn,
  output logic            synthOn,
  output logic            chipOut,
  output logic            powerSetSel,
  output logic      [1:0] channelSel,
  output logic            encoderOn,
  output logic            dataSyncOn,
  output logic            txBufReady
);
  localparam int BITC = `BIT_CYCLES;

  // pin synchronisers
  logic [1:0] enSy_q, sckSy_q, dinSy_q;
  logic       enD_q, sckD_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enSy_q  <= '0;
      sckSy_q <= '0;
      dinSy_q <= '0;
      enD_q   <= 1'b0;
      sckD_q  <= 1'b0;
    end else begin
      enSy_q  <= {enSy_q[0], spiEn};
      sckSy_q <= {sckSy_q[0], spiSck};
      dinSy_q <= {dinSy_q[0], sdioIn};
      enD_q   <= enSy_q[1];
      sckD_q  <= sckSy_q[1];
    end
  end

  logic enS, sckS, dinS, enRise, enFall, sckRise, sckFall;
  assign enS     = enSy_q[1];
  assign sckS    = sckSy_q[1];
  assign dinS    = dinSy_q[1];
  assign enRise  = enS && !enD_q;
  assign enFall  = !enS && enD_q;
  assign sckRise = sckS && !sckD_q;
  assign sckFall = !sckS && sckD_q;

  // clock level at select rise picks the sampling edge
  logic modeHigh_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      modeHigh_q <= 1'b0;
    end else if (enRise) begin
      modeHigh_q <= sckS;
    end
  end

  logic sampleEdge, driveEdge;
  assign sampleEdge = enS && (modeHigh_q ? sckRise : sckFall);
  assign driveEdge  = enS && (modeHigh_q ? sckFall : sckRise);

  // byte assembly
  logic [7:0] rxSh_q;
  logic [2:0] bitCnt_q;
  logic       byteDone;
  logic [7:0] rxByte;
  assign rxByte   = {rxSh_q[6:0], dinS};
  assign byteDone = sampleEdge && (bitCnt_q == 3'h7);
  always_ff @(posedge clk) begin
    if (sys_rst || enRise) begin
      rxSh_q   <= '0;
      bitCnt_q <= '0;
    end else if (sampleEdge) begin
      rxSh_q   <= rxByte;
      bitCnt_q <= bitCnt_q + 3'h1;
    end
  end

  // command decode
  spi_state_t st_q;
  logic [1:0] fc;
  assign fc = rxByte[7:6];                                          // [R2]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
    end else if (enRise) begin
      st_q <= ST_CMD;                                               // [R1]
    end else if (!enS) begin
      st_q <= ST_IDLE;
    end else if (byteDone) begin
      unique case (st_q)
        ST_CMD: begin
          unique case (fc)
            `FC_WRITE:    st_q <= ST_WR;                            // [R3]
            `FC_READ:     st_q <= ST_RD;                            // [R5]
            `FC_TRANSMIT: st_q <= ST_TX;                            // [R7]
            default:      st_q <= ST_SKIP;
          endcase
        end
        ST_IDLE, ST_WR, ST_RD, ST_TX, ST_SKIP: st_q <= st_q;        // [R1]
      endcase
    end
  end

  // control registers
  logic [7:0] regs_q [64];
  logic [5:0] addr_q;
  logic       wrStrobe;
  assign wrStrobe = byteDone && (st_q == ST_WR);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_q <= '0;
    end else if (byteDone && st_q == ST_CMD) begin
      addr_q <= rxByte[5:0];                                        // [R2]
    end else if (wrStrobe) begin
      addr_q <= addr_q + 6'h01;                                     // [R4] [R24]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 64; i++) begin
        regs_q[i] <= '0;
      end
      regs_q[`ADDR_TX_CFG_ONE] <= `TX_CFG_RST;
      regs_q[`ADDR_PRBS_SEED]  <= `PRBS_SEED_RST;
      regs_q[`ADDR_ENC_COUNT]  <= `ENC_COUNT_RST;
    end else if (wrStrobe) begin
      regs_q[addr_q] <= rxByte;                                     // [R3] [R4]
    end
  end

  logic [7:0] txCfg, encCount;
  scheme_t    scheme;
  assign txCfg    = regs_q[`ADDR_TX_CFG_ONE];
  assign encCount = regs_q[`ADDR_ENC_COUNT];
  assign scheme   = scheme_t'(txCfg[2:0]);                          // [R21]

  // read-back on the shared data line
  logic [7:0] rdSh_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdSh_q   <= '0;
      sdioOut  <= 1'b0;
      sdioOe_n <= 1'b1;
    end else if (!enS) begin
      sdioOe_n <= 1'b1;
    end else if (byteDone && st_q == ST_CMD) begin
      rdSh_q <= regs_q[rxByte[5:0]];                                // [R5]
    end else if (driveEdge && st_q == ST_RD) begin
      sdioOut  <= rdSh_q[7];                                        // [R5]
      sdioOe_n <= 1'b0;
      rdSh_q   <= {rdSh_q[6:0], 1'b0};
    end
  end

  // transmit command and amplifier control
  tx_cmd_t txCmd_q;
  logic    holding_q, holdData_q, offPend_q, newTx;
  logic [16:0] holdCnt_q;
  logic    encBusy_q, fifoValid;
  assign newTx = byteDone && st_q == ST_CMD && fc == `FC_TRANSMIT;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txCmd_q    <= '0;
      paOn       <= 1'b0;
      synthOn    <= 1'b0;
      holding_q  <= 1'b0;
      holdData_q <= 1'b0;
      offPend_q  <= 1'b0;
      holdCnt_q  <= '0;
    end else if (newTx) begin
      txCmd_q   <= tx_cmd_t'(rxByte[5:0]);                          // [R23]
      paOn      <= 1'b1;
      synthOn   <= 1'b1;
      holding_q <= 1'b0;
      offPend_q <= 1'b0;
    end else if (enFall && enD_q && st_q == ST_TX) begin
      if (txCmd_q.paHold) begin
        holding_q  <= 1'b1;                                         // [R12]
        holdData_q <= dinS;
        holdCnt_q  <= '0;
      end else if (txCmd_q.dataSync) begin
        offPend_q <= 1'b1;                                          // [R11]
      end else begin
        paOn    <= 1'b0;                                            // [R11]
        synthOn <= 1'b0;
      end
    end else if (holding_q) begin
      if (holdCnt_q == 17'(HOLD_CYCLES - 1)) begin
        holding_q <= 1'b0;                                          // [R12]
        paOn      <= 1'b0;
        synthOn   <= 1'b0;
      end else begin
        holdCnt_q <= holdCnt_q + 17'h0_0001;
      end
    end else if (offPend_q && !encBusy_q && !fifoValid) begin
      offPend_q <= 1'b0;                                            // [R11]
      paOn      <= 1'b0;
      synthOn   <= 1'b0;
    end
  end

  assign powerSetSel = txCmd_q.pwrSel;                              // [R14]
  assign channelSel  = txCmd_q.chan;                                // [R15]
  assign encoderOn   = txCmd_q.encEn;                               // [R13]
  assign dataSyncOn  = txCmd_q.dataSync;

  // datagram buffer
  logic fifoReady, fifoData, popBit, phaseLast;
  sync_fifo #(.WIDTH(1), .DEPTH(4)) u_buf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inValid  (sampleEdge && st_q == ST_TX),
    .inReady  (fifoReady),
    .inData   (dinS),
    .outValid (fifoValid),
    .outReady (popBit),
    .outData  (fifoData)
  );
  assign txBufReady = fifoReady;

  // chip encoder
  logic [4:0] phase_q;
  logic [1:0] chips_q, chipsD;
  logic       lvl_q, prevBit_q, plain;
  logic [7:0] bitIdx_q;
  logic [8:0] prbs_q;
  assign phaseLast = phase_q == 5'(BITC - 1);
  assign popBit    = paOn && !holding_q && (!encBusy_q || phaseLast);
  assign plain     = !txCmd_q.encEn || (bitIdx_q < encCount);        // [R13] [R22]

  function automatic logic [1:0] encodeBit(input scheme_t s, input logic d,
                                           input logic l, input logic p,
                                           input logic r);
    logic [1:0] c;
    c = {d, d};
    unique case (s)
      SCH_MANCH:   c = {d, !d};                                     // [R20]
      SCH_DIFFMAN: c = d ? {l, !l} : {!l, l};
      SCH_BISPACE: c = d ? {!l, !l} : {!l, l};
      SCH_BIMARK:  c = d ? {!l, l} : {!l, !l};
      SCH_MILLER:  c = d ? {l, !l} : (p ? {l, l} : {!l, !l});
      SCH_NRZ:     c = {d, d};                                      // [R19]
      SCH_PRBS:    c = {d ^ r, d ^ r};
      SCH_ZERO:    c = 2'h0;
    endcase
    return c;
  endfunction : encodeBit

  assign chipsD = plain ? {fifoData, fifoData}
                        : encodeBit(scheme, fifoData, lvl_q, prevBit_q, prbs_q[8]);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      encBusy_q <= 1'b0;
      phase_q   <= '0;
      chips_q   <= '0;
      lvl_q     <= 1'b0;
      prevBit_q <= 1'b0;
      bitIdx_q  <= '0;
      prbs_q    <= '0;
    end else if (newTx) begin
      bitIdx_q  <= '0;
      lvl_q     <= 1'b0;
      prevBit_q <= 1'b0;
      prbs_q    <= {1'b0, regs_q[`ADDR_PRBS_SEED]};
    end else if (popBit && fifoValid) begin
      encBusy_q <= 1'b1;
      phase_q   <= '0;
      chips_q   <= chipsD;                                          // [R13] [R19]
      lvl_q     <= chipsD[0];
      prevBit_q <= fifoData;
      prbs_q    <= {prbs_q[7:0], prbs_q[8] ^ prbs_q[4]};
      if (bitIdx_q != 8'hFF) begin
        bitIdx_q <= bitIdx_q + 8'h01;                               // [R22]
      end
    end else if (encBusy_q) begin
      if (phaseLast) begin
        encBusy_q <= 1'b0;
      end else begin
        phase_q <= phase_q + 5'h01;
      end
    end
  end

  logic chipNow;
  assign chipNow = (phase_q < 5'(`CHIP_CYCLES)) ? chips_q[1] : chips_q[0];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chipOut <= 1'b0;
    end else if (holding_q) begin
      chipOut <= holdData_q;                                        // [R12]
    end else if (encBusy_q) begin
      chipOut <= chipNow ^ txCfg[`TX_CFG_INV_BIT];                  // [R21]
    end else begin
      chipOut <= 1'b0;
    end
  end

  // checks
  property p_cmd_write;
    @(posedge clk) disable iff (sys_rst)
      byteDone && st_q == ST_CMD && enS && rxByte[7:6] == 2'h0 |=> st_q == ST_WR;
  endproperty
  a_cmd_write : assert property (p_cmd_write) // [R2] [R3]
    else $error("write code did not enter write state");
  property p_reg_store;
    @(posedge clk) disable iff (sys_rst)
      wrStrobe && enS |=> regs_q[$past(addr_q)] == $past(rxByte);
  endproperty
  a_reg_store : assert property (p_reg_store) // [R3]
    else $error("written byte not stored");
  property p_burst_inc;
    @(posedge clk) disable iff (sys_rst)
      wrStrobe && enS |=> addr_q == $past(addr_q) + 6'h01 ##1 (st_q == ST_WR || !enS);
  endproperty
  a_burst_inc : assert property (p_burst_inc) // [R24]
    else $error("burst address did not advance");
  property p_read_release;
    @(posedge clk) disable iff (sys_rst)
      !enS |=> sdioOe_n;
  endproperty
  a_read_release : assert property (p_read_release) // [R5]
    else $error("data line driven outside a frame");
  property p_tx_fields;
    @(posedge clk) disable iff (sys_rst)
      newTx |=> channelSel == $past(rxByte[1:0]) && powerSetSel == $past(rxByte[2])
                && encoderOn == $past(rxByte[3]) && paOn && synthOn;
  endproperty
  a_tx_fields : assert property (p_tx_fields) // [R7] [R14] [R15] [R23]
    else $error("transmit fields not applied");
  property p_pa_off;
    @(posedge clk) disable iff (sys_rst)
      enFall && st_q == ST_TX && !txCmd_q.paHold && !txCmd_q.dataSync |=> !paOn;
  endproperty
  a_pa_off : assert property (p_pa_off) // [R11]
    else $error("amplifier stayed on after select fall");
  property p_hold_end;
    @(posedge clk) disable iff (sys_rst)
      holding_q && holdCnt_q == 17'(HOLD_CYCLES - 1) && !newTx |=> !paOn && !synthOn
      ##1 chipOut == 1'b0;
  endproperty
  a_hold_end : assert property (p_hold_end) // [R12]
    else $error("hold time-out did not switch off");
  property p_manch_pair;
    @(posedge clk) disable iff (sys_rst)
      popBit && fifoValid && !plain && scheme == SCH_MANCH && !newTx
      |=> chips_q[1] != chips_q[0];
  endproperty
  a_manch_pair : assert property (p_manch_pair) // [R19] [R20]
    else $error("manchester bit lacks two distinct chips");
  property p_plain_lead;
    @(posedge clk) disable iff (sys_rst)
      popBit && fifoValid && plain && !newTx |=> chips_q == {2{$past(fifoData)}};
  endproperty
  a_plain_lead : assert property (p_plain_lead) // [R22]
    else $error("leading bit was encoded");
  c_write : cover property (@(posedge clk) disable iff (sys_rst) wrStrobe ##[1:600] wrStrobe);
  c_read  : cover property (@(posedge clk) disable iff (sys_rst) !sdioOe_n);
  c_hold  : cover property (@(posedge clk) disable iff (sys_rst) holding_q ##1 !holding_q);
  c_encod : cover property (@(posedge clk) disable iff (sys_rst) encBusy_q && !plain);
endmodule : spi_command_and_data_encoder
`default_nettype wire

// ==== sim/host_spi_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
  input  wire logic clk,
  input  wire logic sdioOut,
  input  wire logic sdioOe_n,
  output logic      spiEn,
  output logic      spiSck,
  output logic      sdioLine
);
  localparam int HALF   = 16;
  localparam int SETTLE = 20000;
  logic hostOe;
  logic hostVal;
  logic idleHi;
  // released line falls to the pull-down level
  assign sdioLine = !sdioOe_n ? sdioOut : (hostOe ? hostVal : 1'b0);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // idle levels; sck rests at the level that picks the sampling edge
  task automatic idle(input logic hi);
    idleHi = hi;
    spiEn = 1'b0;
    spiSck = hi;
    hostOe = 1'b0;
    hostVal = 1'b0;
    tick(4);
  endtask : idle
  // msb first, data set on the first sck edge, read back before the second
  task automatic shift_byte(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      hostOe = drive;
      hostVal = tx[i];
      spiSck = !idleHi;
      tick(HALF - 1);
      rx[i] = sdioLine;
      tick(1);
      spiSck = idleHi;
      tick(HALF);
    end
  endtask : shift_byte
  // every frame opens with the command byte
  task automatic open_frame(input logic [7:0] cmd);
    logic [7:0] dummy;
    spiEn = 1'b1;
    tick(HALF);
    shift_byte(cmd, 1'b1, dummy);
  endtask : open_frame
  task automatic end_frame(input logic lvl);
    hostVal = lvl;
    tick(HALF);
    spiEn = 1'b0;
  endtask : end_frame
  task automatic release_line;
    tick(HALF);
    hostOe = 1'b0;
    tick(8);
  endtask : release_line
  task automatic tx_frame(input logic [7:0] cmd, input logic [7:0] data, input int n);
    logic [7:0] dummy;
    open_frame(cmd);
    tick(SETTLE); // settle wait with sck still
    for (int b = 0; b < n; b++) shift_byte(data, 1'b1, dummy); // datagram after command
    end_frame(1'b0);
    release_line();
  endtask : tx_frame
endmodule : host_spi_model
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench import spi_cmd_pkg::*; ();
  localparam int HOLD = 64;
  logic        clk = 1'b0;
  logic        sysRst;
  logic        spiEn;
  logic        spiSck;
  logic        sdioLine;
  logic        sdioOut;
  logic        sdioOe_n;
  logic        paOn;
  logic        synthOn;
  logic        chipOut;
  logic        powerSetSel;
  logic [1:0]  channelSel;
  logic        encoderOn;
  logic        dataSyncOn;
  logic        txBufReady;
  int          onesSeen = 0;
  int          onesBase;
  logic [7:0]  cmd;
  logic [7:0]  rdVal;
  logic [7:0]  fieldsOut;
  int          waited;
  int          miscompares;
  int          comparisons;
  logic [7:0]  fieldCmd [4] = '{8'hC0, 8'hC5, 8'hC2, 8'hEF};
  // scheme cfg, plain count, data byte, chip one expected
  logic [31:0] encCase [5] = '{32'h0700_FF00, 32'h0708_FF01, 32'h0500_0000,
                               32'h0000_0001, 32'h0D00_0001};

  always #2.5 clk = ~clk;
  assign fieldsOut = {3'h0, dataSyncOn, encoderOn, powerSetSel, channelSel};
  always @(posedge clk) if (paOn === 1'b1 && chipOut === 1'b1) onesSeen <= onesSeen + 1;

  spi_command_and_data_encoder #(.HOLD_CYCLES(HOLD)) dut (
    .clk         (clk),
    .sys_rst     (sysRst),
    .spiEn       (spiEn),
    .spiSck      (spiSck),
    .sdioIn      (sdioLine),
    .sdioOut     (sdioOut),
    .sdioOe_n    (sdioOe_n),
    .paOn        (paOn),
    .synthOn     (synthOn),
    .chipOut     (chipOut),
    .powerSetSel (powerSetSel),
    .channelSel  (channelSel),
    .encoderOn   (encoderOn),
    .dataSyncOn  (dataSyncOn),
    .txBufReady  (txBufReady)
  );

  host_spi_model host (
    .clk      (clk),
    .sdioOut  (sdioOut),
    .sdioOe_n (sdioOe_n),
    .spiEn    (spiEn),
    .spiSck   (spiSck),
    .sdioLine (sdioLine)
  );

  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic reg_write(input logic [5:0] addr, input logic [7:0] base, input int n);
    logic [7:0] rx;
    host.open_frame({2'b00, addr}); // addresses kept within 0x04..0x27
    for (int i = 0; i < n; i++) host.shift_byte(base + 8'(i), 1'b1, rx);
    host.end_frame(1'b0);
    host.release_line();
  endtask : reg_write
  task automatic read_expect(input string what, input logic [5:0] addr, input logic [7:0] exp);
    logic [7:0] val;
    host.open_frame({2'b01, addr});
    host.shift_byte(8'h00, 1'b0, val);
    host.end_frame(1'b0);
    host.release_line();
    check(what, val, exp);
  endtask : read_expect
  task automatic wait_pa_off(output int n);
    n = 0;
    while (paOn !== 1'b0 && n < 400) begin
      host.tick(1);
      n++;
    end
    if (paOn !== 1'b0) begin
      miscompares++;
      wrap_up();
    end
  endtask : wait_pa_off

  initial begin
    sysRst = 1'b1;
    miscompares = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    #1;
    sysRst = 1'b0;
    host.idle(1'b0);
    check("bufReady", {7'h00, txBufReady}, 8'h01);
    read_expect("cfg", 6'h05, 8'h25);
    read_expect("seed", 6'h08, 8'hAB);
    read_expect("count", 6'h27, 8'h00);
    reg_write(6'h04, 8'h5A, 1);
    reg_write(6'h10, 8'hC1, 3);
    read_expect("single", 6'h04, 8'h5A);
    for (int i = 0; i < 3; i++) read_expect("burst", 6'h10 + 6'(i), 8'hC1 + 8'(i));
    read_expect("past", 6'h13, 8'h00);
    check("released", {7'h00, sdioOe_n}, 8'h01);
    host.idle(1'b1);
    read_expect("sckHigh", 6'h04, 8'h5A);
    reg_write(6'h13, 8'h3C, 1);
    host.idle(1'b0);
    read_expect("wrHigh", 6'h13, 8'h3C);
    host.open_frame(8'h84);
    host.shift_byte(8'h77, 1'b1, rdVal);
    host.end_frame(1'b0);
    host.release_line();
    read_expect("reserved", 6'h04, 8'h5A);
    foreach (fieldCmd[i]) begin
      cmd = fieldCmd[i];
      host.open_frame(cmd);
      check("fields", fieldsOut, {3'h0, cmd[5], cmd[3:0]});
      check("txOn", {6'h00, paOn, synthOn}, 8'h03);
      host.end_frame(1'b0);
      wait_pa_off(waited);
      check("offLag", {7'h00, waited <= (cmd[5] ? 24 : 6)}, 8'h01);
      check("synthOff", {7'h00, synthOn}, 8'h00);
      host.release_line();
    end
    host.open_frame(8'hD0);
    host.end_frame(1'b1);
    host.tick(8);
    check("holdOn", {6'h00, paOn, chipOut}, 8'h03);
    host.release_line();
    check("holdKeep", {6'h00, paOn, chipOut}, 8'h03);
    wait_pa_off(waited);
    check("holdLen", {7'h00, waited >= HOLD - 32 && waited <= HOLD - 24}, 8'h01);
    check("holdSynth", {7'h00, synthOn}, 8'h00);
    foreach (encCase[i]) begin
      reg_write(6'h05, encCase[i][31:24], 1);
      reg_write(6'h27, encCase[i][23:16], 1);
      onesBase = onesSeen;
      host.tx_frame(8'hE8, encCase[i][15:8], 2); // sync on with encoder on
      wait_pa_off(waited);
      check("chips", {7'h00, onesSeen != onesBase}, {7'h00, encCase[i][0]});
    end
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
